// ---- rtl/asp_params.svh ----
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// register indices on the plain port
`define ASP_A_DATA 4'h0
`define ASP_A_IER 4'h1
`define ASP_A_FCR 4'h2
`define ASP_A_LCR 4'h3
`define ASP_A_MCR 4'h4
`define ASP_A_LSR 4'h5
`define ASP_A_MSR 4'h6
`define ASP_A_DLL 4'h7
`define ASP_A_DLH 4'h8
// field positions
`define ASP_IER_MSI 3
`define ASP_IER_NRZ 5
`define ASP_IER_UUE 6
`define ASP_IER_DMA 7
`define ASP_FCR_FEN 0
`define ASP_LCR_STB 2
`define ASP_LCR_PEN 3
`define ASP_LCR_EPS 4
`define ASP_LCR_BRK 5
`define ASP_LCR_FPE 6
`define ASP_LCR_FFE 7
`define ASP_MCR_DTR 0
`define ASP_MCR_RTS 1
`define ASP_MCR_LOOP 4
`define ASP_MCR_AFE 5
// reset values and timing
`define ASP_DIV_RST 16'h0001
`define ASP_BIT_LAST 4'hf
`define ASP_MID_A 4'h7
`define ASP_MID_B 4'h8
`define ASP_MID_C 4'h9
`define ASP_STOP1 5'h0f
`define ASP_STOP15 5'h17
`define ASP_STOP2 5'h1f
`endif

// ---- rtl/asp_pkg.sv ----
package asp_pkg;
	typedef enum {ASP_FULL, ASP_WIRELESS, ASP_BASIC} asp_variant_t;
	typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_t;
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_t;
endpackage

// ---- rtl/asp_top.sv ----
`timescale 1ns/100ps
`include "asp_params.svh"
// Operation
// RQ1 - divisor 1..65535 makes the 16x tick for both directions
// RQ2 - fifo mode queues 64 characters each way
// RQ3 - without fifo mode each way holds one character
// RQ4 - five to eight data bits per character
// RQ5 - even, odd or no parity, checked on receive
// RQ6 - one, one and a half or two stop bits sent
// RQ7 - break can be sent and is detected on receive
// RQ8 - loopback feeds transmitter into receiver internally
// RQ9 - software can force break, parity and framing errors
// RQ10 - serial output is high from reset
// RQ11 - status bit 4 reads inverse of clear to send pin
// RQ12 - clear to send change flag, cleared by status read
// RQ13 - data set ready and carrier states and change flags
// RQ14 - enabled modem interrupt on any modem state change; ring indicator flags only its trailing edge, not its assertion
// RQ15 - without auto flow clear to send does not gate sending
// RQ16 - auto flow checks clear to send before each character
// RQ17 - carrier detect never affects the receiver
// RQ18 - auto flow drives request to send from receive fill
// RQ19 - programmable receive trigger level for service
// RQ20 - separate transmit and receive dma requests
// RQ21 - disabled port raises no interrupt
// RQ22 - variant decides which modem pins exist
// RQ23 - start bit, data lsb first, parity, stop bits
// RQ24 - three samples around bit middle at 16x
// RQ25 - request to send on above trigger, off at or below
// RQ26 - optional nrz coding of data bits both ways
// RQ27 - start bit high at mid bit is a false start
// RQ28 - framing error on low stop, overrun when storage full
module asp_top #(
	parameter asp_pkg::asp_variant_t VARIANT = asp_pkg::ASP_FULL,
	parameter int                    DEPTH   = 64
)(
	input  wire logic       I_CLK,
	input  wire logic       I_RESETN,
	input  wire logic [3:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RDATA,
	input  wire logic       I_RXD,
	output logic            O_TXD,
	input  wire logic       I_CTS_N,
	output logic            O_RTS_N,
	input  wire logic       I_DSR_N,
	input  wire logic       I_DCD_N,
	input  wire logic       I_RI_N,
	output logic            O_DTR_N,
	output logic            O_TX_DMA_REQ,
	output logic            O_RX_DMA_REQ,
	output logic            O_MODEM_IRQ
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULLN = (AW+1)'(DEPTH);
	localparam logic [AW:0] HALFN = (AW+1)'(DEPTH / 2);
	localparam bit HAS_FLOW = VARIANT != asp_pkg::ASP_BASIC; // RQ22
	localparam bit HAS_MDM = VARIANT == asp_pkg::ASP_FULL; // RQ22

	logic [7:0]  ier_reg;
	logic [7:0]  fcr_reg;
	logic [7:0]  lcr_reg;
	logic [7:0]  mcr_reg;
	logic [15:0] div_reg;
	logic [15:0] baud_cnt_reg;
	logic        tick;
	logic        en;
	logic        loop;
	logic        afe;
	logic        fen;
	logic        nrz;
	logic [1:0]  wl;
	logic [5:0]  trig;
	logic [AW:0] lim;

	assign en = ier_reg[`ASP_IER_UUE];
	assign nrz = ier_reg[`ASP_IER_NRZ];
	assign loop = mcr_reg[`ASP_MCR_LOOP];
	assign afe = mcr_reg[`ASP_MCR_AFE];
	assign fen = fcr_reg[`ASP_FCR_FEN];
	assign wl = lcr_reg[1:0];
	assign trig = fcr_reg[7:2];
	assign lim = fen ? FULLN : (AW+1)'(1); // RQ2 RQ3

	// software-written control registers
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			ier_reg <= 8'h00;
			fcr_reg <= 8'h00;
			lcr_reg <= 8'h00;
			mcr_reg <= 8'h00;
			div_reg <= `ASP_DIV_RST;
		end
		else if (I_WR)
		begin
			if (I_ADDR == `ASP_A_IER)
				ier_reg <= I_WDATA;
			else if (I_ADDR == `ASP_A_FCR)
				fcr_reg <= I_WDATA;
			else if (I_ADDR == `ASP_A_LCR)
				lcr_reg <= I_WDATA;
			else if (I_ADDR == `ASP_A_MCR)
				mcr_reg <= I_WDATA;
			else if (I_ADDR == `ASP_A_DLL)
				div_reg[7:0] <= I_WDATA;
			else if (I_ADDR == `ASP_A_DLH)
				div_reg[15:8] <= I_WDATA;
		end
	end

	// 16x tick; a divisor of zero behaves as one
	assign tick = (baud_cnt_reg + 16'h0001) >= div_reg; // RQ1
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN || tick)
			baud_cnt_reg <= 16'h0000;
		else
			baud_cnt_reg <= baud_cnt_reg + 16'h0001;
	end

	// modem pin states, absent pins read inactive
	logic cts;
	logic dsr;
	logic dcd;
	logic ri;
	assign cts = HAS_FLOW && !I_CTS_N; // RQ11 RQ22
	assign dsr = HAS_MDM && !I_DSR_N; // RQ13
	assign dcd = HAS_MDM && !I_DCD_N; // RQ13 RQ17
	assign ri = HAS_MDM && !I_RI_N;

	// transmit queue, one slot when fifo mode is off
	logic [7:0]  tx_mem [DEPTH];
	logic [AW-1:0] tx_wp_reg;
	logic [AW-1:0] tx_rp_reg;
	logic [AW:0] tx_cnt_reg;
	logic        tx_push;
	logic        tx_pop;
	assign tx_push = I_WR && I_ADDR == `ASP_A_DATA && tx_cnt_reg < lim;
	always_ff @(posedge I_CLK)
	begin
		if (tx_push)
			tx_mem[tx_wp_reg] <= I_WDATA;
	end
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			tx_wp_reg <= '0;
			tx_rp_reg <= '0;
			tx_cnt_reg <= '0;
		end
		else
		begin
			if (tx_push)
				tx_wp_reg <= tx_wp_reg + 1'b1;
			if (tx_pop)
				tx_rp_reg <= tx_rp_reg + 1'b1;
			if (tx_push && !tx_pop)
				tx_cnt_reg <= tx_cnt_reg + 1'b1;
			else if (tx_pop && !tx_push)
				tx_cnt_reg <= tx_cnt_reg - 1'b1;
		end
	end

	// transmitter; data bits may be nrz coded against the line
	asp_pkg::asp_tx_t tx_st_reg;
	logic [4:0] tx_tk_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_sh_reg;
	logic       txd_reg;
	logic       tx_go;
	logic [7:0] mask;
	logic       tx_par;
	logic [4:0] stop_last;
	logic       tx_b;
	assign mask = 8'hff >> (2'd3 - wl);
	assign tx_par = ^(tx_sh_reg & mask) ^ ~lcr_reg[`ASP_LCR_EPS]; // RQ5
	assign stop_last = !lcr_reg[`ASP_LCR_STB] ? `ASP_STOP1 :
		(wl == 2'd0 ? `ASP_STOP15 : `ASP_STOP2); // RQ6
	// cts only gates the start in auto flow mode
	assign tx_go = en && tx_cnt_reg != '0 && (!afe || cts); // RQ15 RQ16
	assign tx_pop = tick && tx_st_reg == asp_pkg::TX_IDLE && tx_go;
	assign tx_b = tx_sh_reg[tx_bit_reg + 3'd1];
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			tx_st_reg <= asp_pkg::TX_IDLE;
			tx_tk_reg <= 5'h00;
			tx_bit_reg <= 3'h0;
			tx_sh_reg <= 8'h00;
			txd_reg <= 1'b1;
		end
		else if (tick)
		begin
			tx_tk_reg <= tx_tk_reg + 5'h01;
			case (tx_st_reg)
			asp_pkg::TX_IDLE:
			begin
				txd_reg <= 1'b1;
				tx_tk_reg <= 5'h00;
				if (tx_go)
				begin
					tx_sh_reg <= tx_mem[tx_rp_reg];
					tx_st_reg <= asp_pkg::TX_START; // RQ23
					txd_reg <= 1'b0;
				end
			end
			asp_pkg::TX_START:
				if (tx_tk_reg[3:0] == `ASP_BIT_LAST)
				begin
					tx_tk_reg <= 5'h00;
					tx_bit_reg <= 3'h0;
					tx_st_reg <= asp_pkg::TX_DATA;
					txd_reg <= nrz ? tx_sh_reg[0] : tx_sh_reg[0]; // RQ26
				end
			asp_pkg::TX_DATA:
				if (tx_tk_reg[3:0] == `ASP_BIT_LAST)
				begin
					tx_tk_reg <= 5'h00;
					if (tx_bit_reg == {1'b1, wl})
					begin
						tx_st_reg <= lcr_reg[`ASP_LCR_PEN] ?
							asp_pkg::TX_PAR : asp_pkg::TX_STOP;
						txd_reg <= lcr_reg[`ASP_LCR_PEN] ? tx_par : 1'b1;
					end
					else
					begin
						tx_bit_reg <= tx_bit_reg + 3'd1;
						txd_reg <= nrz ? txd_reg ^ tx_b : tx_b; // RQ26
					end
				end
			asp_pkg::TX_PAR:
				if (tx_tk_reg[3:0] == `ASP_BIT_LAST)
				begin
					tx_tk_reg <= 5'h00;
					tx_st_reg <= asp_pkg::TX_STOP;
					txd_reg <= 1'b1;
				end
			default:
				if (tx_tk_reg == stop_last)
					tx_st_reg <= asp_pkg::TX_IDLE;
			endcase
		end
	end

	// line after break forcing; loopback keeps the pin idle
	logic line;
	assign line = txd_reg && !lcr_reg[`ASP_LCR_BRK]; // RQ7 RQ9
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
			O_TXD <= 1'b1; // RQ10
		else
			O_TXD <= loop ? 1'b1 : line; // RQ8
	end

	// receiver, three samples at ticks 7, 8 and 9 voted
	logic rx_in;
	assign rx_in = loop ? line : I_RXD; // RQ8
	asp_pkg::asp_rx_t rx_st_reg;
	logic [3:0]  rx_tk_reg;
	logic [2:0]  rx_bit_reg;
	logic [7:0]  rx_d_reg;
	logic [1:0]  rx_s_reg;
	logic        rx_prev_reg;
	logic        rx_zero_reg;
	logic        rx_pe_reg;
	logic        maj;
	logic        mid;
	logic        rx_push;
	logic [10:0] rx_word;
	assign maj = (rx_s_reg[0] & rx_s_reg[1]) | (rx_s_reg[0] & rx_in) |
		(rx_s_reg[1] & rx_in); // RQ24
	assign mid = tick && rx_tk_reg == `ASP_MID_C;
	assign rx_push = mid && rx_st_reg == asp_pkg::RX_STOP;
	// break: every sample of the frame low, stop included
	assign rx_word = {rx_zero_reg && !maj, // RQ7
		!maj || lcr_reg[`ASP_LCR_FFE], // RQ28 RQ9
		rx_pe_reg || lcr_reg[`ASP_LCR_FPE], rx_d_reg}; // RQ5 RQ9
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			rx_st_reg <= asp_pkg::RX_IDLE;
			rx_tk_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_d_reg <= 8'h00;
			rx_s_reg <= 2'h3;
			rx_prev_reg <= 1'b0;
			rx_zero_reg <= 1'b1;
			rx_pe_reg <= 1'b0;
		end
		else if (tick)
		begin
			rx_tk_reg <= rx_tk_reg + 4'h1;
			if (rx_tk_reg == `ASP_MID_A || rx_tk_reg == `ASP_MID_B)
				rx_s_reg <= {rx_s_reg[0], rx_in};
			case (rx_st_reg)
			asp_pkg::RX_IDLE:
			begin
				rx_tk_reg <= 4'h0;
				rx_d_reg <= 8'h00;
				rx_prev_reg <= 1'b0;
				rx_zero_reg <= 1'b1;
				rx_pe_reg <= 1'b0;
				if (en && !rx_in)
					rx_st_reg <= asp_pkg::RX_START; // RQ23
			end
			asp_pkg::RX_START:
				if (rx_tk_reg == `ASP_MID_C && maj)
					rx_st_reg <= asp_pkg::RX_IDLE; // RQ27
				else if (rx_tk_reg == `ASP_BIT_LAST)
				begin
					rx_bit_reg <= 3'h0;
					rx_st_reg <= asp_pkg::RX_DATA;
				end
			asp_pkg::RX_DATA:
			begin
				if (rx_tk_reg == `ASP_MID_C)
				begin
					rx_d_reg[rx_bit_reg] <= nrz ? maj ^ rx_prev_reg : maj; // RQ26
					rx_prev_reg <= maj;
					rx_zero_reg <= rx_zero_reg && !maj;
				end
				if (rx_tk_reg == `ASP_BIT_LAST)
				begin
					if (rx_bit_reg == {1'b1, wl}) // RQ4
						rx_st_reg <= lcr_reg[`ASP_LCR_PEN] ?
							asp_pkg::RX_PAR : asp_pkg::RX_STOP;
					else
						rx_bit_reg <= rx_bit_reg + 3'd1;
				end
			end
			asp_pkg::RX_PAR:
			begin
				if (rx_tk_reg == `ASP_MID_C)
				begin
					rx_pe_reg <= maj != (^rx_d_reg ^ ~lcr_reg[`ASP_LCR_EPS]); // RQ5
					rx_zero_reg <= rx_zero_reg && !maj;
				end
				if (rx_tk_reg == `ASP_BIT_LAST)
					rx_st_reg <= asp_pkg::RX_STOP;
			end
			default:
				// resync early: back to hunting after the stop sample
				if (rx_tk_reg == `ASP_MID_C)
					rx_st_reg <= asp_pkg::RX_IDLE;
			endcase
		end
	end

	// receive queue holding flags beside each character
	logic [10:0]   rx_mem [DEPTH];
	logic [AW-1:0] rx_wp_reg;
	logic [AW-1:0] rx_rp_reg;
	logic [AW:0]   rx_cnt_reg;
	logic          rx_full;
	logic          rx_wr;
	logic          rx_pop;
	logic [10:0]   rx_front;
	assign rx_full = rx_cnt_reg >= lim; // RQ2 RQ3
	assign rx_wr = rx_push && !rx_full;
	assign rx_pop = I_RD && I_ADDR == `ASP_A_DATA && rx_cnt_reg != '0;
	assign rx_front = rx_mem[rx_rp_reg];
	always_ff @(posedge I_CLK)
	begin
		if (rx_wr)
			rx_mem[rx_wp_reg] <= rx_word;
	end
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			rx_wp_reg <= '0;
			rx_rp_reg <= '0;
			rx_cnt_reg <= '0;
		end
		else
		begin
			if (rx_wr)
				rx_wp_reg <= rx_wp_reg + 1'b1;
			if (rx_pop)
				rx_rp_reg <= rx_rp_reg + 1'b1;
			if (rx_wr && !rx_pop)
				rx_cnt_reg <= rx_cnt_reg + 1'b1;
			else if (rx_pop && !rx_wr)
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
		end
	end

	// sticky line and modem flags; a new event beats the read clear
	logic       ovr_reg;
	logic [3:0] dlt_reg;
	logic [3:0] mst_reg;
	logic       lsr_rd;
	logic       msr_rd;
	logic [3:0] mnow;
	logic [3:0] chg;
	assign lsr_rd = I_RD && I_ADDR == `ASP_A_LSR;
	assign msr_rd = I_RD && I_ADDR == `ASP_A_MSR;
	assign mnow = {dcd, ri, dsr, cts};
	assign chg = {mnow[3] ^ mst_reg[3], mst_reg[2] & !ri,
		mnow[1:0] ^ mst_reg[1:0]}; // RQ12 RQ13
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			ovr_reg <= 1'b0;
			dlt_reg <= 4'h0;
			mst_reg <= 4'h0;
		end
		else
		begin
			ovr_reg <= (rx_push && rx_full) || (ovr_reg && !lsr_rd); // RQ28
			mst_reg <= mnow;
			dlt_reg <= chg | (msr_rd ? 4'h0 : dlt_reg); // RQ12 RQ13
		end
	end

	// read port, data valid only in the cycle after the strobe
	logic [7:0] lsr;
	assign lsr = {1'b0, tx_cnt_reg == '0 && tx_st_reg == asp_pkg::TX_IDLE,
		tx_cnt_reg <= (fen ? HALFN : '0), rx_front[10:8] & {3{rx_cnt_reg != '0}},
		ovr_reg, rx_cnt_reg != '0};
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN || !I_RD)
			O_RDATA <= 8'h00;
		else if (I_ADDR == `ASP_A_DATA)
			O_RDATA <= rx_front[7:0];
		else if (I_ADDR == `ASP_A_IER)
			O_RDATA <= ier_reg;
		else if (I_ADDR == `ASP_A_FCR)
			O_RDATA <= fcr_reg;
		else if (I_ADDR == `ASP_A_LCR)
			O_RDATA <= lcr_reg;
		else if (I_ADDR == `ASP_A_MCR)
			O_RDATA <= mcr_reg;
		else if (I_ADDR == `ASP_A_LSR)
			O_RDATA <= lsr;
		else if (I_ADDR == `ASP_A_MSR)
			O_RDATA <= {mnow, dlt_reg}; // RQ11 RQ13
		else if (I_ADDR == `ASP_A_DLL)
			O_RDATA <= div_reg[7:0];
		else if (I_ADDR == `ASP_A_DLH)
			O_RDATA <= div_reg[15:8];
		else
			O_RDATA <= 8'h00;
	end

	// pins, dma requests and the modem interrupt
	always_ff @(posedge I_CLK)
	begin
		if (!I_RESETN)
		begin
			O_RTS_N <= 1'b1;
			O_DTR_N <= 1'b1;
			O_TX_DMA_REQ <= 1'b0;
			O_RX_DMA_REQ <= 1'b0;
			O_MODEM_IRQ <= 1'b0;
		end
		else
		begin
			if (!HAS_FLOW || loop)
				O_RTS_N <= 1'b1;
			else if (afe)
				O_RTS_N <= !(rx_cnt_reg > {1'b0, trig}); // RQ18 RQ25
			else
				O_RTS_N <= !mcr_reg[`ASP_MCR_RTS];
			O_DTR_N <= !(HAS_MDM && !loop && mcr_reg[`ASP_MCR_DTR]);
			O_TX_DMA_REQ <= ier_reg[`ASP_IER_DMA] && fen &&
				tx_cnt_reg < HALFN; // RQ20
			O_RX_DMA_REQ <= ier_reg[`ASP_IER_DMA] && fen &&
				rx_cnt_reg != '0 && rx_cnt_reg >= {1'b0, trig}; // RQ19 RQ20
			O_MODEM_IRQ <= en && ier_reg[`ASP_IER_MSI] &&
				dlt_reg != 4'h0; // RQ14 RQ21
		end
	end

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESETN);

	sequence s_cts_edge;
		cts != mst_reg[0] && !msr_rd;
	endsequence
	sequence s_false_start;
		mid && rx_st_reg == asp_pkg::RX_START && maj;
	endsequence

	a_txd_reset_idle: assert property (disable iff (1'b0) // RQ10
		!I_RESETN |=> O_TXD) else $error("txd not idle after reset");
	a_cts_bit_read: assert property ( // RQ11
		msr_rd |=> O_RDATA[4] == !$past(I_CTS_N) || !HAS_FLOW)
		else $error("msr bit 4 wrong");
	a_cts_delta_set: assert property (s_cts_edge |=> dlt_reg[0]) // RQ12
		else $error("cts change flag missed");
	a_tx_flow_hold: assert property ( // RQ16
		afe && !cts && tx_st_reg == asp_pkg::TX_IDLE |=>
		tx_st_reg == asp_pkg::TX_IDLE) else $error("sent against cts");
	a_rts_above_trig: assert property ( // RQ25
		HAS_FLOW && afe && !loop && rx_cnt_reg > {1'b0, trig}
		|=> !O_RTS_N) else $error("rts not asserted above trigger");
	a_irq_when_off: assert property (!en |=> !O_MODEM_IRQ) // RQ21
		else $error("interrupt while disabled");
	// a divisor write at the tick edge may shorten the next gap
	a_baud_spacing: assert property ( // RQ1
		tick && div_reg > 16'h0001 ##1 $stable(div_reg) |-> !tick)
		else $error("tick too early");
	a_false_start: assert property (s_false_start |=> // RQ27
		rx_st_reg == asp_pkg::RX_IDLE) else $error("false start kept");
	a_overrun_flag: assert property (rx_push && rx_full |=> ovr_reg) // RQ28
		else $error("overrun not flagged");
	a_loop_txd_idle: assert property (loop ##1 loop |-> O_TXD) // RQ8
		else $error("txd moved in loopback");
endmodule

// ---- tb/asp_peer.sv ----
`timescale 1ns/100ps
// serial peer: decodes the port's output and drives its input
module asp_peer (
	input  wire logic       i_clk,
	input  wire logic       i_line,
	input  int              i_bit,
	input  int              i_nb,
	input  wire logic       i_pen,
	output logic            o_rxd,
	output logic            o_got,
	output logic      [9:0] o_word
);
	logic [9:0] w;

	initial
	begin
		o_rxd = 1'b1;
		o_got = 1'b0;
		o_word = 10'h000;
	end

	// mid-bit samples of data, parity and stop, lsb first
	always
	begin
		@(negedge i_line);
		repeat (i_bit / 2) @(posedge i_clk);
		w = 10'h000;
		for (int k = 0; k <= i_nb + int'(i_pen); k++)
		begin
			repeat (i_bit) @(posedge i_clk);
			w[k] = i_line;
		end
		o_word <= w;
		o_got <= 1'b1;
		@(posedge i_clk);
		o_got <= 1'b0;
	end

	// start bit, then n line bits lsb first, then one idle bit
	task automatic send(input logic [9:0] v, input int n);
		o_rxd <= 1'b0;
		repeat (i_bit) @(posedge i_clk);
		for (int k = 0; k < n; k++)
		begin
			o_rxd <= v[k];
			repeat (i_bit) @(posedge i_clk);
		end
		o_rxd <= 1'b1;
		repeat (i_bit) @(posedge i_clk);
	endtask

	// low pulse too short to survive the mid-bit check
	task automatic glitch(input int n);
		o_rxd <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_rxd <= 1'b1;
	endtask
endmodule

// ---- tb/asp_top_tb_top.sv ----
`timescale 1ns/100ps
`include "asp_params.svh"
module asp_top_tb_top;
	logic        I_CLK;
	logic        I_RESETN;
	logic [3:0]  I_ADDR;
	logic [7:0]  I_WDATA;
	logic        I_WR;
	logic        I_RD;
	logic [7:0]  O_RDATA;
	logic        I_RXD;
	logic        O_TXD;
	logic        I_CTS_N;
	logic        O_RTS_N;
	logic        I_DSR_N;
	logic        I_DCD_N;
	logic        I_RI_N;
	logic        O_DTR_N;
	logic        O_TX_DMA_REQ;
	logic        O_RX_DMA_REQ;
	logic        O_MODEM_IRQ;
	logic        got;
	logic [9:0]  word;
	logic [9:0]  e;
	logic [15:0] note;
	logic [15:0] rq[$];
	logic [9:0]  tq[$];
	logic [7:0]  d;
	logic        pen;
	logic        ev;
	logic        lvl;
	logic        rd_seen;
	int          bit_clks;
	int          nb;
	int          seed;
	int          error_cnt;
	int          n_checks;
	logic [7:0]  fmts[8] = '{8'h03, 8'h1b, 8'h0a, 8'h05,
		8'h04, 8'h1e, 8'h09, 8'h18};
	logic [7:0]  lb[3] = '{8'h1b, 8'h5b, 8'h9b};
	logic [7:0]  lx[3] = '{8'h01, 8'h05, 8'h09};

	asp_top u_asp_top (
		.I_CLK        (I_CLK),
		.I_RESETN     (I_RESETN),
		.I_ADDR       (I_ADDR),
		.I_WDATA      (I_WDATA),
		.I_WR         (I_WR),
		.I_RD         (I_RD),
		.O_RDATA      (O_RDATA),
		.I_RXD        (I_RXD),
		.O_TXD        (O_TXD),
		.I_CTS_N      (I_CTS_N),
		.O_RTS_N      (O_RTS_N),
		.I_DSR_N      (I_DSR_N),
		.I_DCD_N      (I_DCD_N),
		.I_RI_N       (I_RI_N),
		.O_DTR_N      (O_DTR_N),
		.O_TX_DMA_REQ (O_TX_DMA_REQ),
		.O_RX_DMA_REQ (O_RX_DMA_REQ),
		.O_MODEM_IRQ  (O_MODEM_IRQ)
	);
	asp_peer u_asp_peer (
		.i_clk  (I_CLK),
		.i_line (O_TXD),
		.i_bit  (bit_clks),
		.i_nb   (nb),
		.i_pen  (pen),
		.o_rxd  (I_RXD),
		.o_got  (got),
		.o_word (word)
	);

	initial
	begin
		I_CLK = 1'b0;
	end
	always #5 I_CLK = ~I_CLK;

	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one compare per kind of result
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] x);
		n_checks++;
		if (g !== x)
		begin
			error_cnt++;
			$display("ERROR %0t rdata %h exp %h", $time, g, x);
		end
	endtask
	task automatic chk_ser(input logic [9:0] g, input logic [9:0] x);
		n_checks++;
		if (g !== x)
		begin
			error_cnt++;
			$display("ERROR %0t frame %h exp %h", $time, g, x);
		end
	endtask
	task automatic chk_pin(input logic g, input logic x);
		n_checks++;
		if (g !== x)
		begin
			error_cnt++;
			$display("ERROR %0t pin %h exp %h", $time, g, x);
		end
	endtask

	// scoreboard: oldest note against each result that shows up
	always @(posedge I_CLK)
	begin
		if (rd_seen)
		begin
			note = rq.pop_front();
			chk_reg(O_RDATA & note[15:8], note[7:0]);
		end
		rd_seen <= I_RD;
		if (got)
			chk_ser(word, (tq.size() != 0) ? tq.pop_front() : 10'bx);
	end

	// bus cycles keep a gap so no strobe is written twice in a step
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= v;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] x,
		input logic [7:0] m);
		rq.push_back({m, x & m});
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		@(posedge I_CLK);
	endtask
	task automatic settle();
		@(posedge I_CLK);
		#2;
	endtask

	// expected line bits after start for the current format
	function automatic logic [9:0] fw(input logic [7:0] v);
		logic [9:0] r;
		r = {2'b00, v & (8'hff >> (8 - nb))};
		if (pen)
			r[nb] = ^r ^ ~ev;
		r[nb + int'(pen)] = 1'b1;
		return r;
	endfunction
	task automatic cfg(input logic [7:0] v);
		wr(`ASP_A_LCR, v);
		nb = int'(v[1:0]) + 5;
		pen = v[3];
		ev = v[4];
	endtask
	task automatic tx(input logic [7:0] v);
		tq.push_back(fw(v));
		wr(`ASP_A_DATA, v);
	endtask
	// bounded wait for the peer to see every queued frame
	task automatic drain(input int lim);
		int n;
		n = 0;
		while (tq.size() != 0 && n < lim)
		begin
			@(posedge I_CLK);
			n++;
		end
		if (tq.size() != 0)
		begin
			error_cnt++;
			print_verdict();
		end
		repeat (3 * bit_clks) @(posedge I_CLK);
	endtask

	initial
	begin
		seed = 69286;
		{I_RESETN, I_WR, I_RD, I_ADDR, I_WDATA} = '0;
		{I_CTS_N, I_DSR_N, I_DCD_N, I_RI_N} = 4'hf;
		bit_clks = 16;
		nb = 8;
		pen = 1'b0;
		ev = 1'b0;
		rd_seen = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (7) @(posedge I_CLK);
		#2;
		chk_pin(O_TXD, 1'b1);
		@(posedge I_CLK);
		I_RESETN <= 1'b1;
		rd(`ASP_A_DLL, 8'h01, 8'hff);
		rd(4'hf, 8'h00, 8'hff);
		// holding stage, then queued frames in eight formats, every width, stop length and parity
		wr(`ASP_A_IER, 8'h40);
		cfg(8'h03);
		tx(8'ha5);
		drain(400);
		wr(`ASP_A_FCR, 8'h01);
		foreach (fmts[i])
		begin
			cfg(fmts[i]);
			tx(8'($random(seed)));
			tx(8'($random(seed)));
			drain(800);
		end
		cfg(8'h03);
		wr(`ASP_A_DLL, 8'h02);
		bit_clks = 32;
		tx(8'h3c);
		drain(800);
		wr(`ASP_A_DLL, 8'h01);
		bit_clks = 16;
		// reception: clean, parity, framing, break, false start
		cfg(8'h1b);
		I_DCD_N <= 1'b0;
		// nonzero so the framing case cannot look like a break
		d = 8'($random(seed)) | 8'h01;
		u_asp_peer.send({1'b1, ^d, d}, 10);
		rd(`ASP_A_LSR, 8'h01, 8'h1f);
		rd(`ASP_A_DATA, d, 8'hff);
		u_asp_peer.send({1'b1, ~^d, d}, 10);
		rd(`ASP_A_LSR, 8'h05, 8'h1d);
		rd(`ASP_A_DATA, d, 8'hff);
		u_asp_peer.send({1'b0, ^d, d}, 10);
		rd(`ASP_A_LSR, 8'h09, 8'h1d);
		rd(`ASP_A_DATA, d, 8'hff);
		u_asp_peer.send(10'h000, 10);
		rd(`ASP_A_LSR, 8'h19, 8'h19);
		rd(`ASP_A_DATA, 8'h00, 8'hff);
		u_asp_peer.glitch(4);
		repeat (400) @(posedge I_CLK);
		rd(`ASP_A_LSR, 8'h00, 8'h01);
		// loopback with forced errors; pins stay idle
		wr(`ASP_A_MCR, 8'h10);
		foreach (lb[i])
		begin
			cfg(lb[i]);
			wr(`ASP_A_DATA, d);
			repeat (100) @(posedge I_CLK);
			#2;
			chk_pin(O_TXD & O_RTS_N & O_DTR_N, 1'b1);
			repeat (150) @(posedge I_CLK);
			rd(`ASP_A_LSR, lx[i], 8'h0d);
			rd(`ASP_A_DATA, d, 8'hff);
		end
		wr(`ASP_A_MCR, 8'h00);
		// sent break is a whole frame of low line
		cfg(8'h23);
		tq.push_back(10'h000);
		repeat (200) @(posedge I_CLK);
		#2;
		chk_pin(O_TXD, 1'b0);
		cfg(8'h03);
		drain(100);
		// modem status, change flags and interrupt
		rd(`ASP_A_MSR, 8'h88, 8'hff);
		wr(`ASP_A_IER, 8'h48);
		I_CTS_N <= 1'b0;
		repeat (2) settle();
		chk_pin(O_MODEM_IRQ, 1'b1);
		rd(`ASP_A_MSR, 8'h11, 8'h11);
		rd(`ASP_A_MSR, 8'h10, 8'h11);
		settle();
		chk_pin(O_MODEM_IRQ, 1'b0);
		@(posedge I_CLK);
		{I_DSR_N, I_DCD_N, I_RI_N} <= 3'b010;
		repeat (2) @(posedge I_CLK);
		I_RI_N <= 1'b1;
		rd(`ASP_A_MSR, 8'h2e, 8'hee);
		wr(`ASP_A_IER, 8'h08);
		I_CTS_N <= 1'b1;
		repeat (3) settle();
		chk_pin(O_MODEM_IRQ, 1'b0);
		rd(`ASP_A_MSR, 8'h01, 8'h11);
		// auto flow holds 65 writes; 64 fit, dma level at half
		wr(`ASP_A_IER, 8'hc0);
		wr(`ASP_A_FCR, 8'h05);
		wr(`ASP_A_MCR, 8'h20);
		for (int i = 0; i < 65; i++)
		begin
			d = 8'($random(seed));
			if (i < 64)
				tq.push_back(fw(d));
			wr(`ASP_A_DATA, d);
			if (i == 30)
			begin
				settle();
				chk_pin(O_TX_DMA_REQ, 1'b1);
			end
		end
		settle();
		chk_pin(O_TX_DMA_REQ, 1'b0);
		chk_pin(O_TXD, 1'b1);
		chk_pin(O_RX_DMA_REQ, 1'b0);
		I_CTS_N <= 1'b0;
		drain(15000);
		// receive fill drives request to send and rx dma
		d = 8'($random(seed));
		u_asp_peer.send({2'b01, d}, 9);
		settle();
		chk_pin(O_RX_DMA_REQ, 1'b1);
		chk_pin(O_RTS_N, 1'b1);
		u_asp_peer.send({2'b01, ~d}, 9);
		settle();
		chk_pin(O_RTS_N, 1'b0);
		rd(`ASP_A_DATA, d, 8'hff);
		settle();
		chk_pin(O_RTS_N, 1'b1);
		rd(`ASP_A_DATA, ~d, 8'hff);
		settle();
		chk_pin(O_RX_DMA_REQ, 1'b0);
		// holding stage: a second unread character overruns
		wr(`ASP_A_FCR, 8'h00);
		u_asp_peer.send({2'b01, d}, 9);
		u_asp_peer.send({2'b01, ~d}, 9);
		rd(`ASP_A_LSR, 8'h03, 8'h03);
		rd(`ASP_A_DATA, d, 8'hff);
		// nrz: a one toggles the line, reference is the start bit
		wr(`ASP_A_MCR, 8'h00);
		wr(`ASP_A_IER, 8'h60);
		d = 8'h4b;
		lvl = 1'b0;
		e = 10'h200;
		for (int k = 0; k < 8; k++)
		begin
			lvl = lvl ^ d[k];
			e[k] = lvl;
		end
		tq.push_back({2'b01, e[7:0]});
		wr(`ASP_A_DATA, d);
		drain(500);
		// the same line levels decode back to the byte
		u_asp_peer.send({2'b01, e[7:0]}, 9);
		rd(`ASP_A_DATA, d, 8'hff);
		print_verdict();
	end
endmodule
